// ==== hdl/rea_pkg.sv ====
package rea_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_TOT_A   = 16'he406;
   localparam logic [15:0] IDX_TOT_B   = 16'he407;
   localparam logic [15:0] IDX_TOT_C   = 16'he408;
   localparam logic [15:0] IDX_FUND_A  = 16'he409;
   localparam logic [15:0] IDX_FUND_B  = 16'he40a;
   localparam logic [15:0] IDX_FUND_C  = 16'he40b;
   localparam logic [15:0] IDX_STATUS  = 16'he502;
   localparam logic [15:0] IDX_ENABLE  = 16'he50a;
   localparam logic [15:0] IDX_PHASE_POWER_SIGN  = 16'he617;
   localparam logic [15:0] IDX_MEASUREMENT_MODE   = 16'he700;
   localparam logic [15:0] IDX_ACCCFG  = 16'he701;
   localparam logic [15:0] IDX_LCYC    = 16'he702;
   localparam logic [15:0] IDX_THR     = 16'hea03;

   // Field positions
   localparam int SIGNCHG_LSB    = 10;
   localparam int TOT_HF_BIT     = 2;
   localparam int FUND_HF_BIT    = 3;
   localparam int SIGN_SEL_BIT   = 1;
   localparam int CLR_RD_BIT     = 6;
   localparam int NEG_FLAG_LSB   = 4;
   localparam int WIRING_LSB     = 4;
   localparam int REACTIVE_ACCUM_SELECT_LSB     = 2;
   localparam int HALF_BIT       = 30;
   localparam int THR_SHIFT      = 27;

   // Reset values
   localparam logic [7:0]  THR_RST    = 8'h03;
   localparam logic [7:0]  MEASUREMENT_MODE_RST  = 8'h00;
   localparam logic [7:0]  ACCCFG_RST = 8'h00;
   localparam logic [7:0]  LCYC_RST   = 8'h00;
   localparam logic [31:0] ENABLE_RST = 32'h0000_0000;

   // Writable-one-to-clear status bits
   localparam logic [31:0] STATUS_W1C = 32'h0000_1c0c;

   // Wiring select codes
   localparam logic [1:0] WIRE_WYE   = 2'h0;
   localparam logic [1:0] WIRE_DELTA = 2'h1;
   localparam logic [1:0] WIRE_NEG_A = 2'h3;

   // Reactive accumulation select: signed sum
   localparam logic [1:0] REACTIVE_ACCUM_SELECT_SIGNED = 2'h0;

endpackage : rea_pkg

// ==== hdl/rea_accumulator.sv ====
`timescale 1ns/1ps
module rea_accumulator #(
   parameter int PW = 28,
   parameter int AW = 40
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // Power datapath
   input  wire logic                   accum_tick,
   input  wire logic [2:0][PW-1:0]     q_tot,
   input  wire logic [2:0][PW-1:0]     q_fund,
   input  wire logic [PW-1:0]          qb_va_tot,
   input  wire logic [PW-1:0]          qb_vc_tot,
   input  wire logic [PW-1:0]          qb_va_fund,
   input  wire logic [PW-1:0]          qb_vc_fund,
   // Avalon-MM slave
   input  wire logic [17:0]            avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   // Interrupt
   output logic                        interrupt_line_zero_n
);

   generate
      if (PW < 2 || PW > 32) begin : g_bad_pw
         $error("rea_accumulator: power width must lie in 2..32");
      end
      if (AW < PW + 3) begin : g_bad_aw_pw
         $error("rea_accumulator: accumulator too narrow for the power input");
      end
      if (AW < 37) begin : g_bad_aw_thr
         $error("rea_accumulator: accumulator too narrow for the threshold");
      end
   endgenerate

   typedef struct packed {
      logic [1:0][2:0][AW-1:0] acc;
      logic [1:0][2:0][31:0]   cnt;
      logic [31:0]             status;
      logic [31:0]             enable;
      logic [15:0]             phase_power_sign;
      logic [7:0]              measurement_mode;
      logic [7:0]              acccfg;
      logic [7:0]              lcyc;
      logic [7:0]              thr;
      logic                    ack;
      logic [31:0]             rdata;
   } rea_state_t;

   rea_state_t s_r;
   rea_state_t s_nxt;

   // Read value of the registers other than the energy counters
   function automatic logic [31:0] reg_read(input rea_state_t       s,
                                            input logic [15:0]      w);
      logic [31:0] r;
      r = 32'h0;
      unique case (w)
         rea_pkg::IDX_STATUS: r = s.status;
         rea_pkg::IDX_ENABLE: r = s.enable;
         rea_pkg::IDX_PHASE_POWER_SIGN: r = {16'h0, s.phase_power_sign};
         rea_pkg::IDX_MEASUREMENT_MODE:  r = {24'h0, s.measurement_mode};
         rea_pkg::IDX_ACCCFG: r = {24'h0, s.acccfg};
         rea_pkg::IDX_LCYC:   r = {24'h0, s.lcyc};
         rea_pkg::IDX_THR:    r = {24'h0, s.thr};
         default: begin
         end
      endcase
      reg_read = r;
   endfunction : reg_read

   logic [1:0][2:0][PW-1:0] q_in;
   logic [1:0][PW-1:0]      qb_va;
   logic [1:0][PW-1:0]      qb_vc;
   logic [15:0]             word;
   logic                    req;

   assign q_in  = {q_fund, q_tot};
   assign qb_va = {qb_va_fund, qb_va_tot};
   assign qb_vc = {qb_vc_fund, qb_vc_tot};
   assign req   = avs_read | avs_write;

   function automatic logic [15:0] word_of(input logic [17:0] a);
      word_of = (a[1:0] == 2'h0) ? a[17:2] : 16'hffff;
   endfunction : word_of

   function automatic logic [15:0] ctr_word(input int t, input int p);
      ctr_word = rea_pkg::IDX_TOT_A + 16'(3 * t + p);
   endfunction : ctr_word

   function automatic logic [AW-1:0] sext(input logic [PW:0] v);
      sext = {{(AW-PW-1){v[PW]}}, v};
   endfunction : sext

   // Byte enables widened to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // Phase B input follows the wiring; the reserved code behaves as wye
   function automatic logic [PW:0] lane_power(input logic [1:0]    wiring,
                                              input int            p,
                                              input logic [PW-1:0] own,
                                              input logic [PW-1:0] va,
                                              input logic [PW-1:0] vc);
      logic [PW:0] r;
      r = {own[PW-1], own};
      if (p == 1) begin
         unique case (wiring)
            rea_pkg::WIRE_DELTA: begin
               r = {va[PW-1], va} - {vc[PW-1], vc};
            end
            rea_pkg::WIRE_NEG_A: begin
               r = -{va[PW-1], va};
            end
            default: begin
               r = {own[PW-1], own};
            end
         endcase
      end
      lane_power = r;
   endfunction : lane_power

   // One first-stage step: add on the strobe, then take off one threshold
   function automatic logic [AW+1:0] stage_one(input logic [AW-1:0] acc,
                                              input logic [PW:0]   pw,
                                              input logic          tick,
                                              input logic [AW-1:0] th);
      logic [AW-1:0] a;
      logic          pos;
      logic          neg;
      a = acc;
      if (tick) begin
         a = a + sext(pw);
      end
      pos = ($signed(a) >= $signed(th));
      neg = ($signed(a) <= -$signed(th));
      if (pos) begin
         a = a - th;
      end else if (neg) begin
         a = a + th;
      end
      stage_one = {pos, neg, a};
   endfunction : stage_one

   // Counter step for one pulse; non-signed modes count every pulse up
   function automatic logic [31:0] pulse_delta(input logic       pos,
                                               input logic       neg,
                                               input logic [1:0] mode);
      logic [31:0] d;
      d = 32'h0;
      if (neg && mode == rea_pkg::REACTIVE_ACCUM_SELECT_SIGNED) begin
         d = 32'hffff_ffff;
      end else if (pos || neg) begin
         d = 32'h0000_0001;
      end
      pulse_delta = d;
   endfunction : pulse_delta

   // Bit 30 moved in either direction: register crossed half scale
   function automatic logic half_flip(input logic [31:0] old_v,
                                      input logic [31:0] new_v);
      half_flip = old_v[rea_pkg::HALF_BIT] != new_v[rea_pkg::HALF_BIT];
   endfunction : half_flip

   // An 8-bit register takes byte lane 0 only
   function automatic logic [7:0] merge8(input logic [7:0]  old_v,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      merge8 = be[0] ? d[7:0] : old_v;
   endfunction : merge8

   // Byte-lane merge for a full-word register
   function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                           input logic [31:0] d,
                                           input logic [31:0] lanes);
      merge32 = (old_v & ~lanes) | (d & lanes);
   endfunction : merge32

   // Write-one-to-clear on the status bits that software may clear
   function automatic logic [31:0] w1c(input logic [31:0] old_v,
                                       input logic [31:0] d,
                                       input logic [31:0] lanes);
      w1c = old_v & ~(d & lanes & rea_pkg::STATUS_W1C);
   endfunction : w1c

   assign word = word_of(avs_address);

   always_comb begin
      logic [AW-1:0]         th;
      logic [AW-1:0]         a;
      logic [PW:0]           pw;
      logic [31:0]           c;
      logic [31:0]           wm;
      logic [31:0]           rd;
      logic [1:0][2:0][31:0] dlt;
      logic                  pos;
      logic                  neg;
      logic [1:0]            hf;
      logic [2:0]            chg;
      logic                  cap;
      logic                  wr;
      th  = '0;
      a   = '0;
      pw  = '0;
      c   = '0;
      rd  = '0;
      dlt = '0;
      pos = 1'b0;
      neg = 1'b0;
      hf  = '0;
      chg = '0;
      s_nxt = s_r;
      wm = lane_mask(avs_byteenable);
      cap = req & ~s_r.ack & avs_read;
      wr  = avs_write & s_r.ack;
      th = {{(AW-35){1'b0}}, s_r.thr, 27'h0};

      // Two-stage integration, one lane per type and phase
      for (int t = 0; t < 2; t++) begin
         for (int p = 0; p < 3; p++) begin
            pw = lane_power(s_r.acccfg[rea_pkg::WIRING_LSB +: 2], p, q_in[t][p],
                            qb_va[t], qb_vc[t]);
            {pos, neg, a} = stage_one(s_r.acc[t][p], pw, accum_tick, th);
            s_nxt.acc[t][p] = a;
            // Sign of energy at pulse; negative means capacitive
            dlt[t][p] = pulse_delta(pos, neg,
                                    s_r.acccfg[rea_pkg::REACTIVE_ACCUM_SELECT_LSB +: 2]);
            c = s_r.cnt[t][p] + dlt[t][p];
            if (half_flip(s_r.cnt[t][p], c)) begin
               hf[t] = 1'b1;
            end
            s_nxt.cnt[t][p] = c;
            // Sign watch on the selected power type
            if ((pos || neg) && t == int'(s_r.measurement_mode[rea_pkg::SIGN_SEL_BIT])) begin
               if (neg != s_r.phase_power_sign[rea_pkg::NEG_FLAG_LSB + p]) begin
                  chg[p] = 1'b1;
                  s_nxt.phase_power_sign[rea_pkg::NEG_FLAG_LSB + p] = neg;
               end
            end
         end
      end

      // Avalon: one wait state, then the answer
      s_nxt.ack = req & ~s_r.ack;
      rd = reg_read(s_r, word);
      for (int t = 0; t < 2; t++) begin
         for (int p = 0; p < 3; p++) begin
            if (word == ctr_word(t, p)) begin
               rd = s_r.cnt[t][p];
               // Clear-on-read keeps the pulse of the capture cycle
               if (cap && s_r.lcyc[rea_pkg::CLR_RD_BIT]) begin
                  s_nxt.cnt[t][p] = dlt[t][p];
               end
            end
         end
      end
      if (cap) begin
         s_nxt.rdata = rd;
      end

      if (wr) begin
         unique case (word)
            rea_pkg::IDX_STATUS: begin
               s_nxt.status = w1c(s_r.status, avs_writedata, wm);
            end
            rea_pkg::IDX_ENABLE: begin
               s_nxt.enable = merge32(s_r.enable, avs_writedata, wm);
            end
            rea_pkg::IDX_MEASUREMENT_MODE: begin
               s_nxt.measurement_mode = merge8(s_r.measurement_mode, avs_writedata, avs_byteenable);
            end
            rea_pkg::IDX_ACCCFG: begin
               s_nxt.acccfg = merge8(s_r.acccfg, avs_writedata, avs_byteenable);
            end
            rea_pkg::IDX_LCYC: begin
               s_nxt.lcyc = merge8(s_r.lcyc, avs_writedata, avs_byteenable);
            end
            rea_pkg::IDX_THR: begin
               s_nxt.thr = merge8(s_r.thr, avs_writedata, avs_byteenable);
            end
            default: begin
            end
         endcase
      end

      // Events set after the clear, so a same-cycle event survives
      for (int p = 0; p < 3; p++) begin
         if (chg[p]) begin
            s_nxt.status[rea_pkg::SIGNCHG_LSB + p] = 1'b1;
         end
      end
      if (hf[0]) begin
         s_nxt.status[rea_pkg::TOT_HF_BIT] = 1'b1;
      end
      if (hf[1]) begin
         s_nxt.status[rea_pkg::FUND_HF_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r        <= '0;
         s_r.enable <= rea_pkg::ENABLE_RST;
         s_r.measurement_mode  <= rea_pkg::MEASUREMENT_MODE_RST;
         s_r.acccfg <= rea_pkg::ACCCFG_RST;
         s_r.lcyc   <= rea_pkg::LCYC_RST;
         s_r.thr    <= rea_pkg::THR_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avs_readdata    = s_r.rdata;
   assign avs_waitrequest = req & ~s_r.ack;
   // Low while any enabled status bit stands
   assign interrupt_line_zero_n = ~|(s_r.status & s_r.enable & rea_pkg::STATUS_W1C);

endmodule : rea_accumulator

// ==== test/rea_dsp_model.sv ====
`timescale 1ns/1ps
module rea_dsp_model #(
   parameter int PW  = 32,
   parameter int DIV = 4
) (
   // Clock
   input  wire logic           core_clk,
   // Power datapath
   output logic                accum_tick,
   output logic [2:0][PW-1:0]  q_tot,
   output logic [2:0][PW-1:0]  q_fund,
   output logic [PW-1:0]       qb_va_tot,
   output logic [PW-1:0]       qb_vc_tot,
   output logic [PW-1:0]       qb_va_fund,
   output logic [PW-1:0]       qb_vc_fund
);
   initial begin
      accum_tick = 1'b0;
      q_tot      = '0;
      q_fund     = '0;
      qb_va_tot  = '0;
      qb_vc_tot  = '0;
      qb_va_fund = '0;
      qb_vc_fund = '0;
   end
   // Same power on all phases, changed only between ticks
   task automatic set_q(input logic [PW-1:0] t, input logic [PW-1:0] f);
      @(posedge core_clk);
      q_tot  <= {3{t}};
      q_fund <= {3{f}};
   endtask : set_q
   // Phase B products for the wiring modes
   task automatic set_b(input logic [PW-1:0] va, input logic [PW-1:0] vc);
      @(posedge core_clk);
      qb_va_tot  <= va;
      qb_vc_tot  <= vc;
      qb_va_fund <= va;
      qb_vc_fund <= vc;
   endtask : set_b
   // One-cycle strobes, DIV cycles apart
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge core_clk);
         accum_tick <= 1'b1;
         @(posedge core_clk);
         accum_tick <= 1'b0;
         repeat (DIV - 2) @(posedge core_clk);
      end
      repeat (4) @(posedge core_clk);
   endtask : ticks
endmodule : rea_dsp_model

// ==== test/rea_accum_monitor.sv ====
`timescale 1ns/1ps
module rea_accum_monitor (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Datapath strobe
   input  wire logic         accum_tick,
   // Register bus
   input  wire logic [17:0]  avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_readdata,
   input  wire logic         avs_waitrequest,
   // Interrupt
   input  wire logic         interrupt_line_zero_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic rdone;
   assign rdone = avs_read && !avs_waitrequest;
   chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait longer than one cycle");
   chk_idle_ready: assert property (avs_waitrequest |-> avs_read || avs_write)
      else $error("wait without request");
   chk_irq_release: assert property ($rose(interrupt_line_zero_n) |-> $past(avs_write && !avs_waitrequest))
      else $error("interrupt released without write");
   chk_irq_cause: assert property ($fell(interrupt_line_zero_n) |-> $past(avs_write) || $past(accum_tick) || $past(accum_tick, 2) || $past(accum_tick, 3))
      else $error("interrupt without cause");
   chk_unmapped_zero: assert property (rdone && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("misaligned read not zero");
   chk_thr_width: assert property (rdone && avs_address == {rea_pkg::IDX_THR, 2'h0} |-> avs_readdata[31:8] == 24'h0)
      else $error("threshold wider than 8 bits");
   chk_sign_width: assert property (rdone && avs_address == {rea_pkg::IDX_PHASE_POWER_SIGN, 2'h0} |-> avs_readdata[31:16] == 16'h0)
      else $error("sign register wider than 16 bits");
   chk_status_bits: assert property (rdone && avs_address == {rea_pkg::IDX_STATUS, 2'h0} |-> (avs_readdata & ~rea_pkg::STATUS_W1C) == 32'h0)
      else $error("status bit outside set");
   chk_rd_stands: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
      else $error("read data changed without read");
endmodule : rea_accum_monitor
bind rea_accumulator rea_accum_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n),
   .accum_tick(accum_tick), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .interrupt_line_zero_n(interrupt_line_zero_n));

// ==== test/reactive_energy_accumulator_test.sv ====
`timescale 1ns/1ps
module reactive_energy_accumulator_test;
   localparam int          PW = 32;
   localparam logic [31:0] TH = 32'h1800_0000;
   logic                   core_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   accum_tick;
   logic [2:0][PW-1:0]     q_tot;
   logic [2:0][PW-1:0]     q_fund;
   logic [PW-1:0]          qb_va_tot, qb_vc_tot, qb_va_fund, qb_vc_fund;
   logic [17:0]            avs_address = 18'h0;
   logic                   avs_read = 1'b0;
   logic                   avs_write = 1'b0;
   logic [31:0]            avs_writedata = 32'h0;
   logic [3:0]             avs_byteenable = 4'hf;
   logic [31:0]            avs_readdata, rd;
   logic                   avs_waitrequest, irq_n;
   int                     bad_count = 0;
   int                     n_tests = 0;
   always #4 core_clk = ~core_clk;
   rea_dsp_model #(.PW(PW), .DIV(4)) dsp_u (.core_clk(core_clk), .accum_tick(accum_tick),
      .q_tot(q_tot), .q_fund(q_fund), .qb_va_tot(qb_va_tot), .qb_vc_tot(qb_vc_tot),
      .qb_va_fund(qb_va_fund), .qb_vc_fund(qb_vc_fund));
   rea_accumulator #(.PW(PW), .AW(40)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .accum_tick(accum_tick), .q_tot(q_tot), .q_fund(q_fund), .qb_va_tot(qb_va_tot),
      .qb_vc_tot(qb_vc_tot), .qb_va_fund(qb_va_fund), .qb_vc_fund(qb_vc_fund),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .interrupt_line_zero_n(irq_n));
   function automatic logic [17:0] ad(input logic [15:0] i);
      return {i, 2'h0};
   endfunction : ad
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
      int t;
      t = 0;
      @(posedge core_clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      // Waitrequest is settled mid-cycle; the answer edge is the next rise
      do begin
         @(negedge core_clk);
         t++;
      end while (avs_waitrequest !== 1'b0 && t < 50);
      @(posedge core_clk);
      rd = avs_readdata;
      chk("answer", {31'h0, t < 50}, 32'h1);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic rdc(input string nm, input logic [17:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask : rdc
   task automatic t_reset;
      rdc("thr", ad(rea_pkg::IDX_THR), 32'h3);
      rdc("status", ad(rea_pkg::IDX_STATUS), 32'h0);
      chk("irq", {31'h0, irq_n}, 32'h1);
   endtask : t_reset
   task automatic t_count;
      bus(1'b1, ad(rea_pkg::IDX_LCYC), 32'h40);
      dsp_u.set_q(TH, TH << 1);
      dsp_u.ticks(5);
      for (int i = 0; i < 3; i++) begin
         rdc("tot", ad(rea_pkg::IDX_TOT_A + 16'(i)), 32'h5);
         rdc("fund", ad(rea_pkg::IDX_FUND_A + 16'(i)), 32'ha);
      end
      rdc("cleared", ad(rea_pkg::IDX_TOT_A), 32'h0);
   endtask : t_count
   task automatic t_sign;
      bus(1'b1, ad(rea_pkg::IDX_ENABLE), 32'h1c00);
      dsp_u.set_q(TH, -(TH << 1));
      dsp_u.ticks(1);
      rdc("total watched", ad(rea_pkg::IDX_STATUS), 32'h8);
      bus(1'b1, ad(rea_pkg::IDX_MEASUREMENT_MODE), 32'h2);
      dsp_u.ticks(1);
      @(negedge core_clk);
      chk("irq low", {31'h0, irq_n}, 32'h0);
      rdc("sign change", ad(rea_pkg::IDX_STATUS), 32'h1c08);
      rdc("sign", ad(rea_pkg::IDX_PHASE_POWER_SIGN), 32'h70);
      bus(1'b1, ad(rea_pkg::IDX_STATUS), 32'h1c0c);
      @(negedge core_clk);
      chk("irq high", {31'h0, irq_n}, 32'h1);
      rdc("w1c", ad(rea_pkg::IDX_STATUS), 32'h0);
      rdc("fund neg", ad(rea_pkg::IDX_FUND_A), 32'hffff_fffc);
      rdc("tot pos", ad(rea_pkg::IDX_TOT_A), 32'h2);
   endtask : t_sign
   task automatic t_wiring;
      logic [1:0]  cd[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
      logic [31:0] ex[4] = '{32'h2, 32'h1, 32'hffff_fffe, 32'h0};
      dsp_u.set_q(32'h0, 32'h0);
      dsp_u.set_b(TH << 1, TH);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, ad(rea_pkg::IDX_ACCCFG), {26'h0, cd[i], 4'h0});
         dsp_u.ticks(1);
         rdc("wiring", ad(rea_pkg::IDX_TOT_B), ex[i]);
      end
      rdc("half full", ad(rea_pkg::IDX_STATUS), 32'h0804);
      bus(1'b1, ad(rea_pkg::IDX_STATUS), 32'h0800);
      bus(1'b1, ad(rea_pkg::IDX_ENABLE), 32'h0000_000c, 4'h1);
      rdc("lanes", ad(rea_pkg::IDX_ENABLE), 32'h1c0c);
      @(negedge core_clk);
      chk("hf irq", {31'h0, irq_n}, 32'h0);
      bus(1'b1, ad(rea_pkg::IDX_STATUS), 32'h0004);
      @(negedge core_clk);
      chk("hf release", {31'h0, irq_n}, 32'h1);
   endtask : t_wiring
   task automatic t_accsel;
      bus(1'b1, ad(rea_pkg::IDX_THR), 32'h6);
      bus(1'b1, ad(rea_pkg::IDX_ACCCFG), 32'h4);
      dsp_u.set_q(-TH, 32'h0);
      dsp_u.ticks(4);
      rdc("absolute", ad(rea_pkg::IDX_TOT_A), 32'h2);
      bus(1'b1, ad(rea_pkg::IDX_ACCCFG), 32'h0);
      dsp_u.ticks(2);
      rdc("wrap", ad(rea_pkg::IDX_TOT_A), 32'hffff_ffff);
      bus(1'b1, ad(rea_pkg::IDX_TOT_A), 32'h1234);
      rdc("read only", ad(rea_pkg::IDX_TOT_A), 32'h0);
      rdc("misaligned", ad(rea_pkg::IDX_THR) | 18'h2, 32'h0);
   endtask : t_accsel
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_count();
      t_sign();
      t_wiring();
      t_accsel();
      end_sim();
   end
endmodule : reactive_energy_accumulator_test
